// *** verilog/gpk_map.svh ***
// Register offsets and reset values of the dual GPIO port block.
// Assumes a 32-bit word-addressed register map; each index is a word.
`ifndef GPK_MAP_SVH
`define GPK_MAP_SVH
// Register indices; byte address is four times the index.
`define GPK_IDX_PA_DATA 8'h00
`define GPK_IDX_PB_DATA 8'h01
`define GPK_IDX_PA_DIR 8'h04
`define GPK_IDX_PB_DIR 8'h05
`define GPK_IDX_PA_CFG 8'h20
`define GPK_IDX_PA_FLAGS 8'h24
`define GPK_IDX_IO_CFG 8'h2a
// Reset values.
`define GPK_RST_DIR8 8'h00
`define GPK_RST_DIR5 5'h00
`define GPK_RST_CFG 8'h00
`define GPK_RST_FLAGS 8'h00
// Bit of the port B data read that shows capture channel one.
`define GPK_PB_CAP1_BIT 5
`endif

// *** verilog/gpk_pkg.sv ***
// Types of the dual GPIO port block.
// Assumes the offsets come from gpk_map.svh.
package gpk_pkg;
  // Port A configuration fields, bit 7 first.
  typedef struct packed {
    logic high_ref_select;
    logic upper_nibble_pullup_off;
    logic upper_nibble_edge_select;
    logic upper_nibble_irq_enable;
    logic lower_nibble_pullup_off;
    logic lower_nibble_edge_select;
    logic lower_nibble_irq_enable;
    logic low_ref_select;
  } gpk_pa_cfg_t;
  // I/O routing configuration fields, bit 7 first.
  typedef struct packed {
    logic capture_xor_enable;
    logic amp_enable;
    logic reserved5;
    logic line4_pwm_enable;
    logic line3_compare_enable;
    logic capture2_source_select;
    logic line1_compare_enable;
    logic capture1_source_select;
  } gpk_io_cfg_t;
  // Port B pin drive group.
  typedef struct packed {
    logic [4:0] out;
    logic [4:0] oe;
  } gpk_pb_drive_t;
endpackage : gpk_pkg

// *** verilog/gpk_gpio.sv ***
// Dual GPIO port block: 8-line port A with keyboard flags, 5-line port B
// shared with timer capture, compare and PWM channels.
// Assumes one clock mclk, synchronous reset rst, Avalon-MM slave access.
`include "gpk_map.svh"
module gpk_gpio (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Avalon-MM slave.
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Port A pins.
  input wire logic [7:0] pa_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe,
  output logic [7:0] pa_pullup_en,
  // Port B pins.
  input wire logic [4:0] pb_in,
  output logic [4:0] pb_out,
  output logic [4:0] pb_oe,
  // Port C lines 0, 2 and 4 for capture routing.
  input wire logic [2:0] pc_cap_in,
  input wire logic pc_cap1_use_line4,
  // Timer, PWM and CPU side.
  input wire logic cmp1_in,
  input wire logic cmp2_in,
  input wire logic line4_pwm_bit,
  input wire logic cpu_irq_mask,
  output logic capture_channel_one,
  output logic capture_channel_two,
  output logic kbd_irq,
  // Converter and amplifier routing.
  output logic converter_high_reference,
  output logic converter_low_reference,
  output logic amp_enable
);
  ////////////////////////////////////////////////////////////////////////
  // Registers.
  // The port data latches have no reset on purpose, so software can load them
  // before it turns a line into an output and avoid a glitch on the pin.
  // Everything that decides direction, routing or interrupts is reset.
  logic [7:0] pa_data_r;
  logic [4:0] pb_data_r;
  logic [7:0] pa_dir_r;
  logic [4:0] pb_dir_r;
  gpk_pkg::gpk_pa_cfg_t cfg_r;
  gpk_pkg::gpk_io_cfg_t io_r;
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic wait_r;
  logic [31:0] rdata_r;
  logic [7:0] pa_s1_r, pa_s2_r, pa_s3_r;
  logic [4:0] pb_s1_r, pb_s2_r;
  logic [2:0] pc_s1_r, pc_s2_r;
  logic [7:0] pa_out_r, pa_oe_r, pa_pu_r;
  gpk_pkg::gpk_pb_drive_t pb_r;
  gpk_pkg::gpk_pb_drive_t pb_nxt;
  logic cap1_r, cap2_r, irq_r, href_r, lref_r, amp_r;

  ////////////////////////////////////////////////////////////////////////
  // Address decode.
  function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
    hit = (a[9:2] == idx) && (a[1:0] == 2'b00);
  endfunction : hit

  // Access completes in the cycle the slave holds waitrequest low.
  // A request is taken only while waitrequest is high, so a master that holds
  // its request over the answer cycle cannot start a second access by accident.
  // Writes without the low byte lane are dropped; every register is one byte.
  wire acc = (avs_read | avs_write) & wait_r;
  wire wr = avs_write & ~wait_r & avs_byteenable[0];
  wire [7:0] wd = avs_writedata[7:0];
  wire h_pa = hit(avs_address, `GPK_IDX_PA_DATA);
  wire h_pb = hit(avs_address, `GPK_IDX_PB_DATA);
  wire h_pad = hit(avs_address, `GPK_IDX_PA_DIR);
  wire h_pbd = hit(avs_address, `GPK_IDX_PB_DIR);
  wire h_cfg = hit(avs_address, `GPK_IDX_PA_CFG);
  wire h_flg = hit(avs_address, `GPK_IDX_PA_FLAGS);
  wire h_io = hit(avs_address, `GPK_IDX_IO_CFG);

  ////////////////////////////////////////////////////////////////////////
  // Capture routing from synchronised lines.
  // Pin sources pass the synchronisers before the selector, so a select
  // change can only swap two clean levels and never passes a metastable value.
  // The capture-two source also feeds the XOR option of capture one.
  wire cap1_src = io_r.capture1_source_select ? pb_s2_r[0] :
                  (pc_cap1_use_line4 ? pc_s2_r[2] : pc_s2_r[0]);
  wire cap2_src = io_r.capture2_source_select ? pb_s2_r[2] : pc_s2_r[1];
  wire cap1_nxt = io_r.capture_xor_enable ? (cap1_src ^ cap2_src) : cap1_src;

  // Read values: latch for outputs, pin for inputs.
  // Reading the latch for outputs keeps read-modify-write sequences from
  // copying a loaded pin level back into the latch.
  // Unmapped indices fall through to zero.
  wire [7:0] pa_rd = (pa_dir_r & pa_data_r) | (~pa_dir_r & pa_s2_r);
  wire [4:0] pb_rd = (pb_dir_r & pb_data_r) | (~pb_dir_r & pb_s2_r);
  wire [7:0] pb_rd8 = {2'b00, cap1_r, pb_rd};
  wire [7:0] rd_mux = h_pa ? pa_rd :
                      h_pb ? pb_rd8 :
                      h_pad ? pa_dir_r :
                      h_pbd ? {3'b000, pb_dir_r} :
                      h_cfg ? cfg_r :
                      h_flg ? flags_r :
                      h_io ? io_r : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Edge detection per line on synchronised samples.
  // The third stage holds the previous synchronised level, so each pin edge
  // gives exactly one single-cycle pulse.
  // Edges that arrive while the group is disabled are dropped, not stored.
  logic [7:0] edge_set;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_edge
      localparam bit UP = (gi >= 4);
      wire rise_sel = UP ? cfg_r.upper_nibble_edge_select :
                           cfg_r.lower_nibble_edge_select;
      wire en = UP ? cfg_r.upper_nibble_irq_enable :
                     cfg_r.lower_nibble_irq_enable;
      wire rise = pa_s2_r[gi] & ~pa_s3_r[gi];
      wire fall = ~pa_s2_r[gi] & pa_s3_r[gi];
      // Selected edge sets the flag only while its group is enabled.
      assign edge_set[gi] = en & (rise_sel ? rise : fall);
    end
  endgenerate

  // Write-one clears; a set in the same cycle wins.
  assign flags_nxt = (flags_r & ~((wr & h_flg) ? wd : 8'h00)) | edge_set;

  ////////////////////////////////////////////////////////////////////////
  // Pin drive and pull-up values.
  // A pull-up fighting an output driver would only waste current, so the
  // pull-up of an output line is off whatever its nibble bit says.
  // Compare and PWM sources replace only the level; direction still gates it.
  wire [1:0] pu_off = {cfg_r.upper_nibble_pullup_off, cfg_r.lower_nibble_pullup_off};
  wire [7:0] pu_nxt = ~pa_dir_r & ~{{4{pu_off[1]}}, {4{pu_off[0]}}};
  always_comb begin
    pb_nxt.out = pb_data_r;
    pb_nxt.oe = pb_dir_r;
    if (io_r.line4_pwm_enable) begin
      pb_nxt.out[4] = line4_pwm_bit;
    end
    if (io_r.line3_compare_enable) begin
      pb_nxt.out[3] = cmp2_in;
    end
    if (io_r.line1_compare_enable) begin
      pb_nxt.out[1] = cmp1_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second.
  // These stages carry no reset: they settle within three cycles of any pin
  // level, and the flags they feed are gated by enables that reset clears.
  always_ff @(posedge mclk) begin
    pa_s1_r <= pa_in;
    pa_s2_r <= pa_s1_r;
    pa_s3_r <= pa_s2_r;
    pb_s1_r <= pb_in;
    pb_s2_r <= pb_s1_r;
    pc_s1_r <= pc_cap_in;
    pc_s2_r <= pc_s1_r;
  end

  // Bus handshake: one wait cycle, then the access completes.
  // Read data is captured in the wait cycle and stands while waitrequest is
  // low, so a master that samples on that edge sees a settled value.
  always_ff @(posedge mclk) begin
    if (rst) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      wait_r <= ~acc;
      if (acc) begin
        rdata_r <= {24'h00_0000, rd_mux};
      end
    end
  end

  // Data latches are never reset and take every write.
  // A write reaches the latch even while the line is an input, so the
  // value is ready for the moment the direction bit turns it into an output.
  always_ff @(posedge mclk) begin
    if (wr & h_pa) begin
      pa_data_r <= wd;
    end
    if (wr & h_pb) begin
      pb_data_r <= wd[4:0];
    end
  end

  // Control registers.
  always_ff @(posedge mclk) begin
    if (rst) begin
      pa_dir_r <= `GPK_RST_DIR8;
      pb_dir_r <= `GPK_RST_DIR5;
      cfg_r <= `GPK_RST_CFG;
      io_r <= `GPK_RST_CFG;
      flags_r <= `GPK_RST_FLAGS;
    end else begin
      if (wr & h_pad) pa_dir_r <= wd;
      if (wr & h_pbd) pb_dir_r <= wd[4:0];
      if (wr & h_cfg) cfg_r <= wd;
      if (wr & h_io) io_r <= wd;
      flags_r <= flags_nxt;
    end
  end

  // Registered outputs.
  // Every pin and routing output comes from a flip-flop, so nothing outside
  // sees decode glitches; the price is one cycle of latency on each output.
  always_ff @(posedge mclk) begin
    if (rst) begin
      pa_out_r <= 8'h00;
      pa_oe_r <= 8'h00;
      pa_pu_r <= 8'h00;
      pb_r <= '0;
      cap1_r <= 1'b0;
      cap2_r <= 1'b0;
      irq_r <= 1'b0;
      href_r <= 1'b0;
      lref_r <= 1'b0;
      amp_r <= 1'b0;
    end else begin
      pa_out_r <= pa_data_r;
      pa_oe_r <= pa_dir_r;
      pa_pu_r <= pu_nxt;
      pb_r <= pb_nxt;
      cap1_r <= cap1_nxt;
      cap2_r <= cap2_src;
      irq_r <= (|flags_r) & ~cpu_irq_mask;
      href_r <= cfg_r.high_ref_select;
      lref_r <= cfg_r.low_ref_select;
      amp_r <= io_r.amp_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output connections.
  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign pa_out = pa_out_r;
  assign pa_oe = pa_oe_r;
  assign pa_pullup_en = pa_pu_r;
  assign pb_out = pb_r.out;
  assign pb_oe = pb_r.oe;
  assign capture_channel_one = cap1_r;
  assign capture_channel_two = cap2_r;
  assign kbd_irq = irq_r;
  assign converter_high_reference = href_r;
  assign converter_low_reference = lref_r;
  assign amp_enable = amp_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks on the block's own registers and outputs.
  // They compare what the block drives with its inputs and stay quiet during reset,
  // apart from the reset check itself.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_dir_reset: assert property (disable iff (1'b0) rst |=> (pa_dir_r == 8'h00) && (pb_dir_r == 5'h00))
    else $error("direction not cleared by reset");
  a_irq_or: assert property ((|flags_r) && !cpu_irq_mask |=> kbd_irq)
    else $error("flag set but no keyboard request");
  a_irq_masked: assert property (cpu_irq_mask |=> !kbd_irq)
    else $error("keyboard request while masked");
  a_flag_edge: assert property (cfg_r.lower_nibble_irq_enable && cfg_r.lower_nibble_edge_select
      && pa_s2_r[2] && !pa_s3_r[2] |=> flags_r[2] ##1 (kbd_irq || $past(cpu_irq_mask)))
    else $error("rising edge did not set flag");
  a_flag_gated: assert property (!cfg_r.upper_nibble_irq_enable && !flags_r[7] |=> !flags_r[7])
    else $error("disabled group set a flag");
  a_flag_clear: assert property (wr && h_flg && wd[2] && !edge_set[2] |=> !flags_r[2])
    else $error("write one did not clear flag");
  a_pa_drive: assert property (##1 pa_oe == $past(pa_dir_r))
    else $error("drive enable differs from direction");
  a_pullup_out: assert property (pa_dir_r[3] |=> !pa_pullup_en[3])
    else $error("pull-up on for output line");
  a_pwm_route: assert property (io_r.line4_pwm_enable && pb_dir_r[4]
      |=> pb_oe[4] && pb_out[4] == $past(line4_pwm_bit))
    else $error("pwm not routed to line 4");
  a_xor_cap: assert property (io_r.capture_xor_enable
      |=> capture_channel_one == ($past(cap1_src) ^ $past(cap2_src)))
    else $error("capture xor wrong");
  a_rd_latch: assert property (avs_read && acc && h_pa |=> !avs_waitrequest
      && (avs_readdata[7:0] & $past(pa_dir_r)) == ($past(pa_data_r) & $past(pa_dir_r)))
    else $error("output read did not return latch");

  // Edge polarity: falling on the lower nibble, rising on the upper nibble.
  a_fall_flag: assert property (cfg_r.lower_nibble_irq_enable && !cfg_r.lower_nibble_edge_select
      && !pa_s2_r[2] && pa_s3_r[2] |=> flags_r[2])
    else $error("falling edge did not set flag");
  a_upper_rise: assert property (cfg_r.upper_nibble_irq_enable && cfg_r.upper_nibble_edge_select
      && pa_s2_r[6] && !pa_s3_r[6] |=> flags_r[6])
    else $error("upper rising edge did not set flag");

  // Bus answer lasts one cycle and port B data shows capture one.
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_pb_cap_bit: assert property (avs_read && acc && h_pb |=> avs_readdata[5] == $past(cap1_r))
    else $error("capture one missing from port B read");

  // Pull-ups, references and the amplifier follow their bits.
  a_pu_nibble: assert property (!cfg_r.lower_nibble_pullup_off && !pa_dir_r[0]
      |=> pa_pullup_en[0])
    else $error("pull-up off on enabled input line");
  a_href_route: assert property (##1 converter_high_reference == $past(cfg_r.high_ref_select))
    else $error("high reference routing wrong");
  a_lref_route: assert property (##1 converter_low_reference == $past(cfg_r.low_ref_select))
    else $error("low reference routing wrong");
  a_amp_route: assert property (##1 amp_enable == $past(io_r.amp_enable))
    else $error("amplifier enable wrong");

  // Port B drive and capture routing.
  a_pb_oe_dir: assert property (##1 pb_oe == $past(pb_dir_r))
    else $error("port B drive enable differs from direction");
  a_cmp1_route: assert property (io_r.line1_compare_enable |=> pb_out[1] == $past(cmp1_in))
    else $error("compare one not routed to line 1");
  a_cmp2_route: assert property (io_r.line3_compare_enable |=> pb_out[3] == $past(cmp2_in))
    else $error("compare two not routed to line 3");
  a_cap2_route: assert property (io_r.capture2_source_select
      |=> capture_channel_two == $past(pb_s2_r[2]))
    else $error("capture two not taken from port B");
  a_cap1_route: assert property (io_r.capture1_source_select && !io_r.capture_xor_enable
      |=> capture_channel_one == $past(pb_s2_r[0]))
    else $error("capture one not taken from port B");

  // Main scenarios.
  c_flag_set: cover property (edge_set[5] ##1 kbd_irq);
  c_read_done: cover property (avs_read ##1 !avs_waitrequest);
  c_write_clear: cover property (wr && h_flg ##1 flags_r == 8'h00);
  c_fall_flag: cover property (edge_set[2] && !cfg_r.lower_nibble_edge_select);
  c_xor_cap: cover property (io_r.capture_xor_enable && capture_channel_one);
endmodule : gpk_gpio

// *** sim/gpk_pin_model.sv ***
// Pin model of the port A lines: switches, pull-ups and floating inputs.
// Assumes the block's output, enable and pull-up levels feed it directly.
module gpk_pin_model (
  // Clock.
  input wire logic mclk,
  // Block side.
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_oe,
  input wire logic [7:0] pa_pullup_en,
  // Switch side.
  input wire logic [7:0] sw_level,
  input wire logic [7:0] sw_drive,
  output logic [7:0] pa_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] float_r = 8'h55;
  ////////////////////////////////////////////////////////////////////////
  // A floating line changes every cycle so it never reads as a stable level.
  always_ff @(posedge mclk) begin
    float_r <= ~float_r;
  end
  // The block wins, then a closed switch, then the pull-up.
  assign pa_in = (pa_oe & pa_out) | (~pa_oe & sw_drive & sw_level) |
    (~pa_oe & ~sw_drive & ((pa_pullup_en) | (~pa_pullup_en & float_r)));
endmodule : gpk_pin_model

// *** sim/gpk_gpio_tb.sv ***
// Self-checking bench of the dual GPIO port block.
// Assumes the block answers over Avalon-MM and the pin model sits on port A.
`include "gpk_map.svh"
module gpk_gpio_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] adr = '0;
  logic rd_q = 1'b0;
  logic wr_q = 1'b0;
  logic [31:0] wd = '0;
  logic [3:0] be = 4'hf;
  logic [31:0] rdat;
  logic wreq;
  logic [7:0] pa_in, pa_out, pa_oe, pa_pu, r;
  logic [7:0] sw_lvl = 8'h03;
  logic [7:0] sw_drv = 8'h0f;
  logic [4:0] pb_in = '0;
  logic [4:0] pb_out, pb_oe;
  logic [2:0] pc = '0;
  logic pc4 = 1'b0, c1 = 1'b0, c2 = 1'b0, pwm = 1'b0, msk = 1'b0;
  logic cap1, cap2, irq, vh, vl, amp;
  int err_total = 0;
  int comparisons = 0;
  ////////////////////////////////////////////////////////////////////////
  // Clock of 5 ns.
  always #2.5 mclk = ~mclk;
  gpk_gpio dut (.mclk(mclk), .rst(rst), .avs_address(adr), .avs_read(rd_q),
    .avs_write(wr_q), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
    .pa_pullup_en(pa_pu), .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe),
    .pc_cap_in(pc), .pc_cap1_use_line4(pc4), .cmp1_in(c1), .cmp2_in(c2),
    .line4_pwm_bit(pwm), .cpu_irq_mask(msk), .capture_channel_one(cap1),
    .capture_channel_two(cap2), .kbd_irq(irq), .converter_high_reference(vh),
    .converter_low_reference(vl), .amp_enable(amp));
  gpk_pin_model pins (.mclk(mclk), .pa_out(pa_out), .pa_oe(pa_oe), .pa_pullup_en(pa_pu),
    .sw_level(sw_lvl), .sw_drive(sw_drv), .pa_in(pa_in));
  ////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude
  // Compares a seen value with the expected one.
  task check(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("wrong value at %0t seen %h expected %h", $time, s, e);
    end
  endtask : check
  // One Avalon access held until waitrequest is sampled low; read data lands in r.
  task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    adr <= {idx, 2'b00};
    rd_q <= !w;
    wr_q <= w;
    wd <= {24'h0, d};
    do begin
      @(posedge mclk);
      n++;
    end while (wreq !== 1'b0 && n < 40);
    r = rdat[7:0];
    rd_q <= 1'b0;
    wr_q <= 1'b0;
    if (n >= 40) begin
      err_total++;
      conclude();
    end
  endtask : bus
  // Waits a number of cycles for synced pins and registered outputs.
  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  ////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    tick(8);
    rst <= 1'b0;
    // Reset values; the direction reset leaves every line an input.
    bus(0, `GPK_IDX_PA_DIR, 0); check(r, `GPK_RST_DIR8);
    bus(0, `GPK_IDX_PB_DIR, 0); check(r, 8'h00);
    bus(0, `GPK_IDX_PA_CFG, 0); check(r, `GPK_RST_CFG);
    bus(0, `GPK_IDX_PA_FLAGS, 0); check(r, `GPK_RST_FLAGS);
    check(pa_oe, 8'h00);
    // Output lines read the latch, input lines the pins.
    bus(1, `GPK_IDX_PA_DATA, 8'h5a);
    bus(1, `GPK_IDX_PA_DIR, 8'hf0);
    tick(4);
    bus(0, `GPK_IDX_PA_DATA, 0); check(r, 8'h53);
    check(pa_oe, 8'hf0);
    check(pa_out & pa_oe, 8'h50);
    // A write without the low byte lane is ignored, and an unmapped index reads as zero.
    be <= 4'he;
    bus(1, `GPK_IDX_PA_DIR, 8'h00);
    be <= 4'hf;
    bus(0, `GPK_IDX_PA_DIR, 0); check(r, 8'hf0);
    bus(0, 8'h3f, 0); check(r, 8'h00);
    // Pull-ups per nibble, never on output lines.
    bus(1, `GPK_IDX_PA_CFG, 8'h08); tick(2); check(pa_pu, 8'h00);
    bus(1, `GPK_IDX_PA_DIR, 8'h00);
    bus(1, `GPK_IDX_PA_CFG, 8'h40); tick(2); check(pa_pu, 8'h0f);
    // Reference routing with lines 0 and 7 kept as inputs.
    bus(1, `GPK_IDX_PA_CFG, 8'hc9); tick(2); check({vh, vl}, 2'b11);
    bus(1, `GPK_IDX_PA_CFG, 8'h00); tick(2); check({vh, vl}, 2'b00);
    // Keyboard flags: lower nibble rising, upper nibble disabled.
    sw_drv <= 8'hff;
    sw_lvl <= 8'h00;
    tick(6);
    bus(1, `GPK_IDX_PA_CFG, 8'h06);
    bus(1, `GPK_IDX_PA_FLAGS, 8'hff);
    sw_lvl <= 8'h24;
    tick(6);
    bus(0, `GPK_IDX_PA_FLAGS, 0); check(r, 8'h04);
    check(irq, 1'b1);
    msk <= 1'b1;
    tick(3); check(irq, 1'b0);
    msk <= 1'b0;
    bus(1, `GPK_IDX_PA_FLAGS, 8'hfb);
    bus(0, `GPK_IDX_PA_FLAGS, 0); check(r, 8'h04);
    bus(1, `GPK_IDX_PA_FLAGS, 8'h04);
    bus(0, `GPK_IDX_PA_FLAGS, 0); check(r, 8'h00);
    tick(3); check(irq, 1'b0);
    // Falling edge on the lower nibble, rising on the enabled upper nibble.
    bus(1, `GPK_IDX_PA_CFG, 8'h32);
    sw_lvl <= 8'h60;
    tick(6);
    bus(0, `GPK_IDX_PA_FLAGS, 0); check(r, 8'h44);
    // Port B compare and PWM routing, driven only as outputs.
    bus(1, `GPK_IDX_PB_DATA, 8'h01);
    bus(1, `GPK_IDX_PB_DIR, 8'h1f);
    bus(1, `GPK_IDX_IO_CFG, 8'h1a);
    c1 <= 1'b1;
    c2 <= 1'b1;
    pwm <= 1'b1;
    tick(3); check(pb_out, 5'h1b); check(pb_oe, 5'h1f);
    pwm <= 1'b0;
    tick(3); check(pb_out, 5'h0b);
    bus(1, `GPK_IDX_IO_CFG, 8'h00); tick(2); check(pb_out, 5'h01);
    // Capture routing and the XOR option, seen on the capture outputs and once through port B data.
    bus(1, `GPK_IDX_PB_DIR, 8'h00);
    bus(1, `GPK_IDX_IO_CFG, 8'h05);
    pb_in <= 5'h01;
    tick(5); check({cap1, cap2}, 2'b10);
    bus(0, `GPK_IDX_PB_DATA, 0); check(r & 8'h3f, 8'h21);
    pb_in <= 5'h04;
    tick(5); check({cap1, cap2}, 2'b01);
    bus(1, `GPK_IDX_IO_CFG, 8'h85); tick(3); check(cap1, 1'b1);
    bus(1, `GPK_IDX_IO_CFG, 8'h00);
    pc <= 3'b011;
    tick(5); check({cap1, cap2}, 2'b11);
    pc4 <= 1'b1;
    tick(3); check(cap1, 1'b0);
    // Amplifier enable with line 4 already an input.
    bus(1, `GPK_IDX_IO_CFG, 8'h40); tick(2); check(amp, 1'b1);
    bus(1, `GPK_IDX_IO_CFG, 8'h00); tick(2); check(amp, 1'b0);
    // A mid-run reset clears directions and keeps the data latches.
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(3); check(pb_out, 5'h01); check(pb_oe, 5'h00);
    conclude();
  end
endmodule : gpk_gpio_tb
